// ==== include/uml_cfg.svh ====
// Purpose: offsets, field positions, reset values and counts of the modem/line status block
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes: printed offsets are word indexes; byte address is four times the index
`ifndef UML_CFG_SVH
`define UML_CFG_SVH

// register indexes and byte addresses
`define UML_IDX_MODEM_CONTROL 5'h04
`define UML_IDX_LINE_STATUS 5'h05
`define UML_IDX_MODEM_STATUS 5'h06
`define UML_ADDR_W 5
`define UML_ADDR_MODEM_CONTROL 5'h10
`define UML_ADDR_LINE_STATUS 5'h14
`define UML_ADDR_MODEM_STATUS 5'h18

// modem control fields
`define UML_MC_TERMINAL_READY 0
`define UML_MC_SEND_REQUEST 1
`define UML_MC_GENERAL_OUT_ONE 2
`define UML_MC_IRQ_GATE 3
`define UML_MC_LOOPBACK 4
`define UML_MC_WIDTH 5
`define UML_MC_RESET 5'h00

// line status fields
`define UML_LS_DATA_READY 0
`define UML_LS_OVERRUN 1
`define UML_LS_PARITY 2
`define UML_LS_FRAMING 3
`define UML_LS_BREAK 4
`define UML_LS_HOLD_EMPTY 5
`define UML_LS_ALL_EMPTY 6
`define UML_LS_FIFO_ERROR 7

// modem status fields: deltas in 3:0, levels in 7:4
`define UML_MS_DELTA_LSB 0
`define UML_MS_LEVEL_LSB 4

// bus responses
`define UML_RESP_OKAY 2'h0
`define UML_RESP_SLVERR 2'h2

// receive timing in 16x baud ticks
`define UML_TICKS_PER_BIT 8'h10
`define UML_HALF_BIT_TICKS 8'h08
`define UML_BREAK_CNT_W 8

`endif

// ==== include/uml_pkg.sv ====
// Purpose: shared types of the modem/line status block
// Assumes: constants come from uml_cfg.svh
// Notes: modem levels are carried active high inside the block
package uml_pkg;

    // one received character's report from the receiver
    typedef struct packed {
        logic push;
        logic parity_err;
        logic framing_err;
        logic break_err;
    } uml_rx_evt_t;

    // modem handshake levels, active high
    typedef struct packed {
        logic carrier;
        logic ring;
        logic set_ready;
        logic clear_send;
    } uml_modem_t;

endpackage

// ==== verilog/uml_modem_line_status.sv ====
// Purpose: modem control, line status and modem status registers of a serial port
// Assumes: receiver, transmitter, fifos and interrupt priority logic are neighbours on the same clock
// Notes: registers are reached over AXI4-Lite; pins are synchronised by three flops
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "uml_cfg.svh"

// Functional notes
// - control bit 0 drives terminal ready low
// - control bit 1 drives send request low
// - control bit 2 is cpu-only flag
// - control bit 3 enables the interrupt pin
// - loopback idles serial out, loops transmit data
// - loopback feeds control bits to modem inputs
// - control bits 5 to 7 read zero
// - data ready set on character, cleared empty
// - overrun set on overwrite, read clears
// - parity error flagged, fifo shows at top
// - framing error on zero stop bit
// - after framing error, low is start bit
// - break after long low, half-bit high restart
// - line errors raise line status interrupt
// - holding empty set on move, write clears
// - all-empty when holding and shift empty
// - fifo error summary bit, zero without fifo
// - delta bits on send, ready, carrier changes
// - ring trailing edge flag, read clears
// - any delta raises modem status interrupt
// - status bits 4-6 show inverted inputs
// - status bit 7 shows inverted carrier
module uml_modem_line_status
    import uml_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // axi4-lite write channels
    input wire logic [`UML_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read channels
    input wire logic [`UML_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial and modem pins
    input wire logic serial_in_pin,
    input wire logic clear_send_in_n,
    input wire logic set_ready_in_n,
    input wire logic ring_in_n,
    input wire logic carrier_in_n,
    output logic serial_out_pin,
    output logic terminal_ready_out_n,
    output logic send_request_out_n,
    output logic irq_pin_out,
    output logic irq_pin_oe,
    // receiver side
    input wire uml_rx_evt_t rx_evt,
    input wire uml_rx_evt_t rx_top,
    input wire logic rx_top_new,
    input wire logic rx_empty,
    input wire logic rx_fifo_full,
    input wire logic rx_fifo_err_present,
    input wire logic baud_tick16,
    input wire logic [3:0] char_bits,
    output logic rx_line,
    output logic rx_resync,
    output logic rx_enable,
    output logic break_char_push,
    // transmitter side
    input wire logic tx_serial,
    input wire logic tx_hold_write,
    input wire logic tx_hold_to_shift,
    input wire logic tx_shift_busy,
    input wire logic tx_fifo_empty,
    // mode, enables and interrupt hookup
    input wire logic fifo_mode,
    input wire logic [3:0] irq_enable,
    input wire logic irq_request,
    output logic line_status_irq,
    output logic hold_empty_irq,
    output logic modem_status_irq,
    output logic loopback
);

    logic [`UML_MC_WIDTH-1:0] modem_control;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] pin_stable;
    uml_modem_t modem_now;
    uml_modem_t modem_prev;
    logic [3:0] modem_delta;
    logic rx_data_ready;
    logic overrun_flag;
    logic parity_fail_flag;
    logic framing_fail_flag;
    logic break_flag;
    logic tx_holding_empty;
    logic tx_all_empty;
    logic fifo_err_flag;
    logic [`UML_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    logic rd_take;
    logic line_status_read;
    logic modem_status_read;
    logic [7:0] line_status;
    logic [7:0] modem_status;
    logic [7:0] next_rdata;
    logic [`UML_BREAK_CNT_W+3:0] low_ticks;
    logic [`UML_BREAK_CNT_W-1:0] high_ticks;
    logic [`UML_BREAK_CNT_W+3:0] char_ticks;
    logic in_break;
    logic break_detect;
    logic top_errs;

    // both halves held, no answer pending
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign line_status_read = rd_take && (s_axi_araddr == `UML_ADDR_LINE_STATUS);
    assign modem_status_read = rd_take && (s_axi_araddr == `UML_ADDR_MODEM_STATUS);

    // aw and w in either order, then response
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `UML_RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                // unmapped addresses error
                if (aw_addr == `UML_ADDR_MODEM_CONTROL || aw_addr == `UML_ADDR_LINE_STATUS ||
                    aw_addr == `UML_ADDR_MODEM_STATUS) begin
                    s_axi_bresp <= `UML_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `UML_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // modem control; low byte lane only
    always_ff @(posedge clock) begin
        if (rst) begin
            modem_control <= `UML_MC_RESET;
        end else if (wr_fire && aw_addr == `UML_ADDR_MODEM_CONTROL && w_strb[0]) begin
            modem_control <= w_data[`UML_MC_WIDTH-1:0];
        end
    end

    // captured at the taking edge, before read side effects
    always_comb begin
        next_rdata = 8'h00;
        case (s_axi_araddr)
            `UML_ADDR_MODEM_CONTROL: next_rdata = {3'h0, modem_control};
            `UML_ADDR_LINE_STATUS: next_rdata = line_status;
            `UML_ADDR_MODEM_STATUS: next_rdata = modem_status;
            default: next_rdata = 8'h00;
        endcase
    end

    // read channel: one read in flight
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `UML_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, next_rdata};
                if (s_axi_araddr == `UML_ADDR_MODEM_CONTROL || s_axi_araddr == `UML_ADDR_LINE_STATUS ||
                    s_axi_araddr == `UML_ADDR_MODEM_STATUS) begin
                    s_axi_rresp <= `UML_RESP_OKAY;
                end else begin
                    s_axi_rresp <= `UML_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // three-flop sync; flops two and three must agree
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1 <= 5'h1f;
            sync2 <= 5'h1f;
            sync3 <= 5'h1f;
            pin_stable <= 5'h1f;
        end else begin
            sync1 <= {serial_in_pin, carrier_in_n, ring_in_n, set_ready_in_n, clear_send_in_n};
            sync2 <= sync1;
            sync3 <= sync2;
            pin_stable <= (sync2 & sync3) | (pin_stable & (sync2 ^ sync3));
        end
    end

    // loopback swaps the pins for control bits
    always_comb begin
        if (modem_control[`UML_MC_LOOPBACK]) begin
            modem_now.clear_send = modem_control[`UML_MC_SEND_REQUEST];
            modem_now.set_ready = modem_control[`UML_MC_TERMINAL_READY];
            modem_now.ring = modem_control[`UML_MC_GENERAL_OUT_ONE];
            modem_now.carrier = modem_control[`UML_MC_IRQ_GATE];
        end else begin
            modem_now.clear_send = ~pin_stable[0];
            modem_now.set_ready = ~pin_stable[1];
            modem_now.ring = ~pin_stable[2];
            modem_now.carrier = ~pin_stable[3];
        end
    end

    // change detect; set beats read clear
    always_ff @(posedge clock) begin
        if (rst) begin
            modem_prev <= '0;
            modem_delta <= 4'h0;
        end else begin
            modem_prev <= modem_now;
            modem_delta[0] <= (modem_now.clear_send ^ modem_prev.clear_send) |
                              (modem_delta[0] & ~modem_status_read);
            modem_delta[1] <= (modem_now.set_ready ^ modem_prev.set_ready) |
                              (modem_delta[1] & ~modem_status_read);
            // ring pin rising means active-high ring falling
            modem_delta[2] <= (modem_prev.ring & ~modem_now.ring) |
                              (modem_delta[2] & ~modem_status_read);
            modem_delta[3] <= (modem_now.carrier ^ modem_prev.carrier) |
                              (modem_delta[3] & ~modem_status_read);
        end
    end

    // current levels in the top nibble
    assign modem_status = {modem_now.carrier, modem_now.ring, modem_now.set_ready,
                           modem_now.clear_send, modem_delta};

    // data ready: new char beats empty
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_data_ready <= 1'b0;
        end else if (rx_evt.push || break_char_push) begin
            rx_data_ready <= 1'b1;
        end else if (rx_empty) begin
            rx_data_ready <= 1'b0;
        end
    end

    // overrun: unread char overwritten, or fifo full
    always_ff @(posedge clock) begin
        if (rst) begin
            overrun_flag <= 1'b0;
        end else if (rx_evt.push && (fifo_mode ? rx_fifo_full : rx_data_ready)) begin
            overrun_flag <= 1'b1;
        end else if (line_status_read) begin
            overrun_flag <= 1'b0;
        end
    end

    // char errors: direct, or from the fifo top
    always_ff @(posedge clock) begin
        if (rst) begin
            parity_fail_flag <= 1'b0;
            framing_fail_flag <= 1'b0;
            break_flag <= 1'b0;
        end else if (fifo_mode) begin
            parity_fail_flag <= (rx_top_new & rx_top.parity_err) |
                                (parity_fail_flag & ~line_status_read);
            framing_fail_flag <= (rx_top_new & rx_top.framing_err) |
                                 (framing_fail_flag & ~line_status_read);
            break_flag <= (rx_top_new & rx_top.break_err) | (break_flag & ~line_status_read);
        end else begin
            parity_fail_flag <= (rx_evt.push & rx_evt.parity_err) |
                                (parity_fail_flag & ~line_status_read);
            framing_fail_flag <= (rx_evt.push & rx_evt.framing_err) |
                                 (framing_fail_flag & ~line_status_read);
            break_flag <= break_detect | (break_flag & ~line_status_read);
        end
    end

    // summary kept while errors remain
    assign top_errs = rx_evt.push & (rx_evt.parity_err | rx_evt.framing_err | rx_evt.break_err);
    always_ff @(posedge clock) begin
        if (rst) begin
            fifo_err_flag <= 1'b0;
        end else if (!fifo_mode) begin
            fifo_err_flag <= 1'b0;
        end else if (top_errs || break_char_push) begin
            fifo_err_flag <= 1'b1;
        end else if (line_status_read) begin
            fifo_err_flag <= rx_fifo_err_present;
        end
    end

    // outside fifo mode, move into shifter wins over cpu write
    always_ff @(posedge clock) begin
        if (rst) begin
            tx_holding_empty <= 1'b1;
            tx_all_empty <= 1'b1;
        end else begin
            if (fifo_mode) begin
                tx_holding_empty <= tx_fifo_empty & ~tx_hold_write;
            end else if (tx_hold_to_shift) begin
                tx_holding_empty <= 1'b1;
            end else if (tx_hold_write) begin
                tx_holding_empty <= 1'b0;
            end
            tx_all_empty <= tx_holding_empty & ~tx_shift_busy & ~tx_hold_write;
        end
    end

    assign line_status = {fifo_err_flag, tx_all_empty, tx_holding_empty, break_flag,
                          framing_fail_flag, parity_fail_flag, overrun_flag, rx_data_ready};

    // break watch in 16x ticks; char_bits is whole frame
    assign char_ticks = {4'h0, char_bits, 4'h0};
    always_ff @(posedge clock) begin
        if (rst) begin
            low_ticks <= '0;
            high_ticks <= '0;
            in_break <= 1'b0;
            break_detect <= 1'b0;
            break_char_push <= 1'b0;
            rx_enable <= 1'b1;
        end else begin
            break_detect <= 1'b0;
            break_char_push <= 1'b0;
            if (rx_line) begin
                low_ticks <= '0;
                if (baud_tick16 && in_break) begin
                    high_ticks <= high_ticks + 8'h01;
                end
                // restart only after half a bit of idle line
                if (in_break && high_ticks >= `UML_HALF_BIT_TICKS) begin
                    in_break <= 1'b0;
                    rx_enable <= 1'b1;
                end
            end else begin
                high_ticks <= '0;
                if (baud_tick16 && !in_break) begin
                    low_ticks <= low_ticks + 12'h001;
                end
                if (!in_break && low_ticks > char_ticks) begin
                    in_break <= 1'b1;
                    rx_enable <= 1'b0;
                    break_detect <= 1'b1;
                    break_char_push <= fifo_mode; // one zero character per break in fifo mode
                end
            end
        end
    end

    // framing error, line low: new start bit
    always_ff @(posedge clock) begin
        if (rst) begin
            rx_resync <= 1'b0;
        end else begin
            rx_resync <= rx_evt.push & rx_evt.framing_err & ~rx_line;
        end
    end

    // pins; loopback idles modem outputs and serial out
    always_ff @(posedge clock) begin
        if (rst) begin
            serial_out_pin <= 1'b1;
            terminal_ready_out_n <= 1'b1;
            send_request_out_n <= 1'b1;
            rx_line <= 1'b1;
            loopback <= 1'b0;
        end else begin
            loopback <= modem_control[`UML_MC_LOOPBACK];
            serial_out_pin <= modem_control[`UML_MC_LOOPBACK] | tx_serial;
            rx_line <= modem_control[`UML_MC_LOOPBACK] ? tx_serial : pin_stable[4];
            terminal_ready_out_n <= modem_control[`UML_MC_LOOPBACK] |
                                    ~modem_control[`UML_MC_TERMINAL_READY];
            send_request_out_n <= modem_control[`UML_MC_LOOPBACK] |
                                  ~modem_control[`UML_MC_SEND_REQUEST];
        end
    end

    // irqs live on in loopback, gated by enables
    always_ff @(posedge clock) begin
        if (rst) begin
            line_status_irq <= 1'b0;
            hold_empty_irq <= 1'b0;
            modem_status_irq <= 1'b0;
            irq_pin_out <= 1'b0;
            irq_pin_oe <= 1'b0;
        end else begin
            line_status_irq <= irq_enable[2] &
                (overrun_flag | parity_fail_flag | framing_fail_flag | break_flag);
            hold_empty_irq <= irq_enable[1] & tx_holding_empty;
            modem_status_irq <= irq_enable[3] & (|modem_delta);
            // pin floats unless the gate bit is set; loopback does not change this
            irq_pin_oe <= modem_control[`UML_MC_IRQ_GATE];
            irq_pin_out <= irq_request & modem_control[`UML_MC_IRQ_GATE];
        end
    end

endmodule

// ==== testbench/uml_assertions.sv ====
// Purpose: port checks of the modem/line status block
// Assumes: one clock, synchronous reset
// Notes: pins and irqs lag their cause by one edge
`timescale 1ns/10ps
module uml_assertions (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // causes
    input wire logic s_axi_bvalid,
    input wire logic tx_serial,
    input wire logic irq_request,
    input wire logic [3:0] irq_enable,
    input wire logic loopback,
    // effects
    input wire logic serial_out_pin,
    input wire logic terminal_ready_out_n,
    input wire logic send_request_out_n,
    input wire logic irq_pin_out,
    input wire logic irq_pin_oe,
    input wire logic line_status_irq,
    input wire logic hold_empty_irq,
    input wire logic modem_status_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // two edges of loopback leave both modem outputs and serial out idle
    property p_lb_idle;
        loopback && $past(loopback) |-> terminal_ready_out_n && send_request_out_n && serial_out_pin;
    endproperty
    a_lb_idle: assert property (p_lb_idle) else $error("output active in loopback");
    // outside loopback the line follows the shifter a cycle late
    property p_ser_out;
        !$past(rst) && !loopback && !$past(loopback) |-> serial_out_pin == $past(tx_serial);
    endproperty
    a_ser_out: assert property (p_ser_out) else $error("serial out lost tx data");
    // no drive means no level on the interrupt pin
    property p_irq_hiz;
        !irq_pin_oe |-> !irq_pin_out;
    endproperty
    a_irq_hiz: assert property (p_irq_hiz) else $error("irq driven while off");
    property p_irq_pass;
        irq_pin_oe |-> irq_pin_out == $past(irq_request);
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq pin not passing request");
    // each interrupt needs its enable one edge before
    property p_ms_irq;
        modem_status_irq |-> $past(irq_enable[3]);
    endproperty
    a_ms_irq: assert property (p_ms_irq) else $error("modem irq while masked");
    property p_ls_irq;
        line_status_irq |-> $past(irq_enable[2]);
    endproperty
    a_ls_irq: assert property (p_ls_irq) else $error("line irq while masked");
    property p_he_irq;
        hold_empty_irq |-> $past(irq_enable[1]);
    endproperty
    a_he_irq: assert property (p_he_irq) else $error("holding irq while masked");
    // the pin moves only right after a register write
    property p_dtr_chg;
        $changed(terminal_ready_out_n) |-> $past(s_axi_bvalid);
    endproperty
    a_dtr_chg: assert property (p_dtr_chg) else $error("ready pin moved without write");
endmodule

// ==== testbench/uml_modem_model.sv ====
// Purpose: far-side modem driving the handshake and serial pins
// Assumes: the bench asks for active-high line levels
// Notes: DLY sets how slowly the modem follows a request
`timescale 1ns/10ps
module uml_modem_model
    import uml_pkg::*;
#(
    parameter int DLY = 2
) (
    // bench request
    input wire logic clock,
    input wire uml_modem_t want,
    // modem pins, active low; serial held at mark, no frames sent
    output logic clear_send_in_n,
    output logic set_ready_in_n,
    output logic ring_in_n,
    output logic carrier_in_n,
    output logic serial_in_pin
);
    logic [4*DLY-1:0] dly_line = '0;
    // pins follow want DLY edges late
    always_ff @(posedge clock) begin
        dly_line <= {dly_line[4*DLY-5:0], want};
    end
    assign {carrier_in_n, ring_in_n, set_ready_in_n, clear_send_in_n} = ~dly_line[4*DLY-1 -: 4];
    assign serial_in_pin = 1'b1;
endmodule

// ==== testbench/uml_modem_line_status_test.sv ====
// Purpose: self-checking bench of the modem/line status block
// Assumes: bus answers come when they come; every wait is bounded
// Notes: bus expectations queue up and a monitor compares them
`timescale 1ns/10ps
`include "uml_cfg.svh"
module uml_modem_line_status_test;
    import uml_pkg::*;
    logic clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 32'h1608, r;
    logic [3:0] s_axi_wstrb = 4'hf, irq_enable = 4'he, char_bits = 4'ha;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic serial_in_pin, clear_send_in_n, set_ready_in_n, ring_in_n, carrier_in_n;
    logic serial_out_pin, terminal_ready_out_n, send_request_out_n, irq_pin_out, irq_pin_oe;
    logic rx_top_new = 0, rx_empty = 1, rx_fifo_full = 0, rx_fifo_err_present = 0, baud_tick16 = 0;
    logic tx_serial = 1, tx_hold_write = 0, tx_hold_to_shift = 0, tx_shift_busy = 0, tx_fifo_empty = 1;
    logic fifo_mode = 0, irq_request = 0, rx_line, rx_resync, rx_enable, break_char_push;
    logic line_status_irq, hold_empty_irq, modem_status_irq, loopback;
    uml_rx_evt_t rx_evt = 0, rx_top = 0;
    uml_modem_t want = 0;
    logic [33:0] exq[$];
    int num_errors = 0, tests_run = 0;
    uml_modem_line_status i_dut (.*);
    uml_modem_model #(.DLY(3)) i_modem (.*);
    initial forever #2.5 clock = ~clock;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded edge wait
    task automatic tick(inout int n);
        @(posedge clock);
        n++;
        if (n > 64) begin
            num_errors++;
            $display("mismatch at %0t: bus timeout", $time);
            final_report();
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e = `UML_RESP_OKAY);
        int n = 0;
        logic aw = 1, w = 1;
        exq.push_back({e, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (aw || w) begin
            tick(n);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do tick(n); while (!s_axi_bvalid);
        s_axi_bready <= 0;
        tick(n);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] e = `UML_RESP_OKAY);
        int n = 0;
        exq.push_back({e, 24'h0, d});
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do tick(n); while (!s_axi_rvalid);
        s_axi_rready <= 0;
        tick(n);
    endtask
    // one rx report, flag and irq edges
    task automatic ev(input uml_rx_evt_t e);
        rx_evt <= e;
        @(posedge clock);
        rx_evt <= 0;
        repeat (2) @(posedge clock);
    endtask
    // bus answers against oldest note
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready)
            chk({s_axi_rresp, s_axi_rdata}, exq.pop_front());
        if (s_axi_bvalid && s_axi_bready)
            chk({s_axi_bresp, 32'h0}, exq.pop_front());
    end
    // noise on tick, shifter output and irq request
    always @(posedge clock) begin
        r = xs();
        {irq_request, tx_serial, baud_tick16} <= r[2:0];
    end
    initial begin
        logic [7:0] v;
        repeat (4) @(posedge clock);
        rst <= 0;
        rd(`UML_ADDR_MODEM_CONTROL, 8'h00);
        rd(`UML_ADDR_LINE_STATUS, 8'h60);
        rd(5'h00, 8'h00, `UML_RESP_SLVERR);
        wr(5'h1c, 8'hff, `UML_RESP_SLVERR);
        wr(`UML_ADDR_LINE_STATUS, 8'h00);
        chk(hold_empty_irq, 1'b1);
        for (int n = 0; n < 6; n++) begin
            v = xs() & 32'hef;
            wr(`UML_ADDR_MODEM_CONTROL, v);
            rd(`UML_ADDR_MODEM_CONTROL, v & 8'h0f);
            chk({terminal_ready_out_n, send_request_out_n, irq_pin_oe}, {!v[0], !v[1], v[3]});
        end
        // four changes from pins, then via loopback
        for (int n = 0; n < 2; n++) begin
            irq_enable[3] <= n[0];
            if (n) wr(`UML_ADDR_MODEM_CONTROL, 8'h1f);
            else want <= 4'hf;
            repeat (16) @(posedge clock);
            chk({modem_status_irq, terminal_ready_out_n, loopback}, {n[0], n[0] | !v[0], n[0]});
            rd(`UML_ADDR_MODEM_STATUS, 8'hfb);
            rd(`UML_ADDR_MODEM_STATUS, 8'hf0);
            if (n) wr(`UML_ADDR_MODEM_CONTROL, 8'h10);
            else want <= 4'h0;
            repeat (16) @(posedge clock);
            rd(`UML_ADDR_MODEM_STATUS, 8'h0f);
            rd(`UML_ADDR_MODEM_STATUS, 8'h00);
        end
        wr(`UML_ADDR_MODEM_CONTROL, 8'h00);
        rx_empty <= 0;
        ev(4'hc);
        chk(line_status_irq, 1'b1);
        rd(`UML_ADDR_LINE_STATUS, 8'h65);
        ev(4'h8);
        ev(4'ha);
        rd(`UML_ADDR_LINE_STATUS, 8'h6b);
        rd(`UML_ADDR_LINE_STATUS, 8'h61);
        rx_empty <= 1;
        tx_hold_write <= 1;
        tx_shift_busy <= 1;
        @(posedge clock);
        tx_hold_write <= 0;
        repeat (2) @(posedge clock);
        chk(hold_empty_irq, 1'b0);
        rd(`UML_ADDR_LINE_STATUS, 8'h00);
        tx_hold_to_shift <= 1;
        @(posedge clock);
        tx_hold_to_shift <= 0;
        rd(`UML_ADDR_LINE_STATUS, 8'h20);
        tx_shift_busy <= 0;
        // fifo mode: error reported with the top character
        {fifo_mode, rx_fifo_err_present, rx_top_new, rx_empty, rx_top, rx_evt} <= 12'he4c;
        @(posedge clock);
        {rx_top_new, rx_evt} <= 0;
        repeat (2) @(posedge clock);
        rd(`UML_ADDR_LINE_STATUS, 8'he5);
        rx_fifo_err_present <= 0;
        rd(`UML_ADDR_LINE_STATUS, 8'he1);
        rd(`UML_ADDR_LINE_STATUS, 8'h61);
        final_report();
    end
endmodule
bind uml_modem_line_status uml_assertions i_chk (.*);
